// ### pkg/vrbc_consts.vh
`ifndef VRBC_CONSTS_VH
`define VRBC_CONSTS_VH

// Register offsets
`define VRBC_ADDR_SRC_SEL     8'h04
`define VRBC_ADDR_OUT_EN      8'h05
`define VRBC_ADDR_GAIN_CLAMP  8'h06
`define VRBC_ADDR_BLANK_CTL   8'h07

// Reset values
`define VRBC_RST_SRC_SEL      8'h99
`define VRBC_RST_OUT_EN       8'h00
`define VRBC_RST_GAIN_CLAMP   8'h04
`define VRBC_RST_BLANK_CTL    8'h00

// video_source_select fields
`define VRBC_TV_SEL_LSB       0
`define VRBC_VCR_SEL_LSB      3
`define VRBC_RF_SEL_LSB       6

// video_output_enables fields
`define VRBC_EN_TV_COMP       0
`define VRBC_EN_TV_RED        1
`define VRBC_EN_TV_GREEN      2
`define VRBC_EN_TV_BLUE       3
`define VRBC_EN_VCR_COMP      4
`define VRBC_EN_VCR_CHROMA    5
`define VRBC_EN_TV_FB         6
`define VRBC_CHROMA_DIR       7

// video_gain_clamp fields
`define VRBC_GAIN_LSB         0
`define VRBC_CLAMP_VCR        2
`define VRBC_CLAMP_ENC        3
`define VRBC_CLAMP_SHARED     4
`define VRBC_CLAMP_GREEN      5
`define VRBC_RESTORE_LSB      6

// blanking_control fields
`define VRBC_FB_LSB           0
`define VRBC_SBT_LSB          2
`define VRBC_SBV_LSB          4
`define VRBC_SBIO_LSB         6

// Fixed loop-through routing
`define VRBC_TV_LOOP          3'h4
`define VRBC_VCR_LOOP         3'h3
`define VRBC_RF_LOOP          2'h2
`define VRBC_RESTORE_AUTO     2'h2

// Analog source codes on the switch matrix selects
`define VRBC_SRC_NONE         4'h0
`define VRBC_SRC_ENC_COMP1    4'h1
`define VRBC_SRC_ENC_LUMA2    4'h2
`define VRBC_SRC_ENC_RC       4'h3
`define VRBC_SRC_ENC_CHROMA2  4'h4
`define VRBC_SRC_ENC_GREEN    4'h5
`define VRBC_SRC_ENC_BLUE     4'h6
`define VRBC_SRC_VCR_COMP     4'h7
`define VRBC_SRC_VCR_RC       4'h8
`define VRBC_SRC_VCR_GREEN    4'h9
`define VRBC_SRC_VCR_BLUE     4'ha
`define VRBC_SRC_TV_COMP      4'hb

`endif

// ### rtl/vrbc_sync2.v
`timescale 1ns/1ps
module vrbc_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             mclk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta   <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule // vrbc_sync2

// ### rtl/vrbc_ctrl.v
// How it works
// - Auto-setup or standby overrides the TV, VCR and RF source selects with fixed loop-through routing.
// - TV code 001 routes encoder composite, red, green, blue to TV outputs.
// - TV codes 010/011 route encoder pair one or two; green, blue float.
// - TV 100 routes VCR inputs, 101 TV composite only, 000 all float.
// - VCR selector picks off, encoder pairs, TV composite, or VCR inputs.
// - RF selector picks encoder composite, encoder green, VCR composite, or floats.
// - RF code 01 with TV 001 and green on carries TV green signal.
// - Seven enable bits each make one video output active; zero floats it.
// - Auto-setup ignores the per-output enable bits.
// - Chroma direction one grounds VCR chroma pin; zero follows its enable.
// - Two-bit RGB gain code selects 6, 7.2, 8.2 or 9.1 dB.
// - VCR clamp pair picks 0.7V, red biased 2.2V, or both 2.2V.
// - Encoder clamp pair decodes RGB, Y/C, YPbPr the same way.
// - Green clamp bit picks sync-tip; forced under TV 001, green on, source 11.
// - Restore sync source selects among four inputs; forced VCR composite in auto.
// - TV fast blank: low, high, mirror VCR fast blank input; 11 reserved.
// - TV slow blank level: low, middle, high; code 10 reserved.
// - VCR slow blank level likewise, applying only while its pin drives.
// - Direction field: both drive, VCR input with TV own level, or mirrored.
// - Slow blank status holds its last capture while VCR pin drives.
`timescale 1ns/1ps
`include "vrbc_consts.vh"
module vrbc_ctrl (
  input  wire       mclk_i,
  input  wire       reset_n_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  input  wire       auto_setup_i,
  input  wire       standby_i,
  input  wire       vcr_fast_blank_i,
  input  wire [1:0] vcr_slow_blank_i,
  output reg  [3:0] tv_composite_src_o,
  output reg        tv_composite_oe_o,
  output reg  [3:0] tv_red_src_o,
  output reg        tv_red_oe_o,
  output reg  [3:0] tv_green_src_o,
  output reg        tv_green_oe_o,
  output reg  [3:0] tv_blue_src_o,
  output reg        tv_blue_oe_o,
  output reg  [3:0] vcr_composite_src_o,
  output reg        vcr_composite_oe_o,
  output reg  [3:0] vcr_chroma_src_o,
  output reg        vcr_chroma_oe_o,
  output reg        vcr_chroma_gnd_o,
  output reg  [3:0] modulator_src_o,
  output reg        modulator_oe_o,
  output reg  [1:0] rgb_gain_o,
  output reg        vcr_rc_clamp_high_o,
  output reg        vcr_blue_clamp_high_o,
  output reg        enc_rc_clamp_high_o,
  output reg        enc_blue_clamp_high_o,
  output reg        enc_green_sync_tip_o,
  output reg  [1:0] restore_sync_src_o,
  output reg        tv_fast_blank_o,
  output reg        tv_fast_blank_oe_o,
  output reg  [1:0] tv_slow_blank_level_o,
  output reg        tv_slow_blank_oe_o,
  output reg  [1:0] vcr_slow_blank_level_o,
  output reg        vcr_slow_blank_oe_o,
  output reg  [1:0] vcr_slow_blank_status_o
);
  wire       rst_n;
  reg  [7:0] video_source_select;
  reg  [7:0] video_output_enables;
  reg  [7:0] video_gain_clamp;
  reg  [7:0] blanking_control;
  wire       fb_sync;
  wire [1:0] sb_sync;

  wire [2:0] tv_source_sel        = video_source_select[`VRBC_TV_SEL_LSB +: 3];
  wire [2:0] vcr_source_sel       = video_source_select[`VRBC_VCR_SEL_LSB +: 3];
  wire [1:0] rf_source_sel        = video_source_select[`VRBC_RF_SEL_LSB +: 2];
  wire       tv_green_out_en      = video_output_enables[`VRBC_EN_TV_GREEN];
  wire       tv_fast_blank_out_en = video_output_enables[`VRBC_EN_TV_FB];
  wire       chroma_direction_ctl = video_output_enables[`VRBC_CHROMA_DIR];
  wire       vcr_input_clamp_sel  = video_gain_clamp[`VRBC_CLAMP_VCR];
  wire       enc_input_clamp_sel  = video_gain_clamp[`VRBC_CLAMP_ENC];
  wire       shared_clamp_sel     = video_gain_clamp[`VRBC_CLAMP_SHARED];
  wire       enc_green_clamp_sel  = video_gain_clamp[`VRBC_CLAMP_GREEN];
  wire [1:0] restore_sync_source  = video_gain_clamp[`VRBC_RESTORE_LSB +: 2];
  wire [1:0] tv_fast_blank_level  = blanking_control[`VRBC_FB_LSB +: 2];
  wire [1:0] tv_slow_blank_level  = blanking_control[`VRBC_SBT_LSB +: 2];
  wire [1:0] vcr_slow_blank_level = blanking_control[`VRBC_SBV_LSB +: 2];
  wire [1:0] slow_blank_direction = blanking_control[`VRBC_SBIO_LSB +: 2];
  wire       loop_through         = auto_setup_i | standby_i;

  reg  [2:0] tv_code, vcr_code;
  reg  [1:0] rf_code, en_vcr, vcr_valid;
  reg  [3:0] en_tv, tv_valid;
  reg  [3:0] next_tv_comp_src, next_tv_red_src, next_tv_green_src, next_tv_blue_src;
  reg  [3:0] next_vcr_comp_src, next_vcr_chroma_src, next_rf_src;
  reg        next_rf_oe, next_vcr_chroma_oe, next_vcr_chroma_gnd, next_sync_tip;
  reg        next_vcr_rc_high, next_vcr_blue_high, next_enc_rc_high, next_enc_blue_high;
  reg        next_fb, next_fb_oe, next_tv_sb_oe, next_vcr_sb_oe;
  reg  [1:0] next_restore_src, next_tv_sb_level, next_vcr_sb_level, next_sb_status;
  reg  [7:0] next_rdata;

  // Release the asynchronous reset through two flip-flops
  vrbc_sync2 #(.WIDTH(1)) u_reset_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (reset_n_i),
    .async_i (1'b1),
    .sync_o  (rst_n)
  );

  vrbc_sync2 #(.WIDTH(3)) u_blank_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .async_i ({vcr_slow_blank_i, vcr_fast_blank_i}),
    .sync_o  ({sb_sync, fb_sync})
  );

  // Register writes
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      video_source_select  <= `VRBC_RST_SRC_SEL;
      video_output_enables <= `VRBC_RST_OUT_EN;
      video_gain_clamp     <= `VRBC_RST_GAIN_CLAMP;
      blanking_control     <= `VRBC_RST_BLANK_CTL;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `VRBC_ADDR_SRC_SEL:    video_source_select  <= reg_wdata_i;
        `VRBC_ADDR_OUT_EN:     video_output_enables <= reg_wdata_i;
        `VRBC_ADDR_GAIN_CLAMP: video_gain_clamp     <= reg_wdata_i;
        `VRBC_ADDR_BLANK_CTL:  blanking_control     <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Video switch matrix
  always @* begin
    tv_code  = loop_through ? `VRBC_TV_LOOP  : tv_source_sel;
    vcr_code = loop_through ? `VRBC_VCR_LOOP : vcr_source_sel;
    rf_code  = loop_through ? `VRBC_RF_LOOP  : rf_source_sel;
    en_tv    = auto_setup_i ? 4'hf : video_output_enables[3:0];
    en_vcr   = auto_setup_i ? 2'h3 : video_output_enables[5:4];
    next_tv_comp_src  = `VRBC_SRC_NONE;
    next_tv_red_src   = `VRBC_SRC_NONE;
    next_tv_green_src = `VRBC_SRC_NONE;
    next_tv_blue_src  = `VRBC_SRC_NONE;
    tv_valid          = 4'h0;
    case (tv_code)
      3'h1: begin
        next_tv_comp_src  = `VRBC_SRC_ENC_COMP1;
        next_tv_red_src   = `VRBC_SRC_ENC_RC;
        next_tv_green_src = `VRBC_SRC_ENC_GREEN;
        next_tv_blue_src  = `VRBC_SRC_ENC_BLUE;
        tv_valid          = 4'hf;
      end
      3'h2: begin
        next_tv_comp_src  = `VRBC_SRC_ENC_COMP1;
        next_tv_red_src   = `VRBC_SRC_ENC_RC;
        tv_valid          = 4'h3;
      end
      3'h3: begin
        next_tv_comp_src  = `VRBC_SRC_ENC_LUMA2;
        next_tv_red_src   = `VRBC_SRC_ENC_CHROMA2;
        tv_valid          = 4'h3;
      end
      3'h4: begin
        next_tv_comp_src  = `VRBC_SRC_VCR_COMP;
        next_tv_red_src   = `VRBC_SRC_VCR_RC;
        next_tv_green_src = `VRBC_SRC_VCR_GREEN;
        next_tv_blue_src  = `VRBC_SRC_VCR_BLUE;
        tv_valid          = 4'hf;
      end
      3'h5: begin
        next_tv_comp_src  = `VRBC_SRC_TV_COMP;
        tv_valid          = 4'h1;
      end
      default: tv_valid   = 4'h0;
    endcase
    next_vcr_comp_src   = `VRBC_SRC_NONE;
    next_vcr_chroma_src = `VRBC_SRC_NONE;
    vcr_valid           = 2'h0;
    case (vcr_code)
      3'h1: begin
        next_vcr_comp_src   = `VRBC_SRC_ENC_COMP1;
        next_vcr_chroma_src = `VRBC_SRC_ENC_RC;
        vcr_valid           = 2'h3;
      end
      3'h2: begin
        next_vcr_comp_src   = `VRBC_SRC_ENC_LUMA2;
        next_vcr_chroma_src = `VRBC_SRC_ENC_CHROMA2;
        vcr_valid           = 2'h3;
      end
      3'h3: begin
        next_vcr_comp_src   = `VRBC_SRC_TV_COMP;
        vcr_valid           = 2'h1;
      end
      3'h4: begin
        next_vcr_comp_src   = `VRBC_SRC_VCR_COMP;
        next_vcr_chroma_src = `VRBC_SRC_VCR_RC;
        vcr_valid           = 2'h3;
      end
      default: vcr_valid    = 2'h0;
    endcase
    next_rf_oe = 1'b1;
    case (rf_code)
      2'h0: next_rf_src = `VRBC_SRC_ENC_COMP1;
      // Same encoder green source as TV green under TV code 001
      2'h1: next_rf_src = `VRBC_SRC_ENC_GREEN;
      2'h2: next_rf_src = `VRBC_SRC_VCR_COMP;
      default: begin
        next_rf_src = `VRBC_SRC_NONE;
        next_rf_oe  = 1'b0;
      end
    endcase
    // Chroma pin: grounded, floating or driven
    next_vcr_chroma_gnd = chroma_direction_ctl;
    next_vcr_chroma_oe  = !chroma_direction_ctl && en_vcr[1] && vcr_valid[1];
  end

  // Clamp, gain and blanking decode
  always @* begin
    case ({shared_clamp_sel, vcr_input_clamp_sel})
      2'h0:    {next_vcr_rc_high, next_vcr_blue_high} = 2'b00;
      2'h1:    {next_vcr_rc_high, next_vcr_blue_high} = 2'b10;
      2'h2:    {next_vcr_rc_high, next_vcr_blue_high} = 2'b11;
      default: {next_vcr_rc_high, next_vcr_blue_high} = 2'b00;
    endcase
    case ({shared_clamp_sel, enc_input_clamp_sel})
      2'h0:    {next_enc_rc_high, next_enc_blue_high} = 2'b00;
      2'h1:    {next_enc_rc_high, next_enc_blue_high} = 2'b10;
      2'h2:    {next_enc_rc_high, next_enc_blue_high} = 2'b11;
      default: {next_enc_rc_high, next_enc_blue_high} = 2'b00;
    endcase
    next_sync_tip = enc_green_clamp_sel ||
                    (tv_source_sel == 3'h1 && tv_green_out_en &&
                     restore_sync_source == 2'h3);
    next_restore_src = auto_setup_i ? `VRBC_RESTORE_AUTO : restore_sync_source;
    next_fb_oe = (tv_fast_blank_out_en || auto_setup_i) &&
                 (tv_fast_blank_level != 2'h3);
    case (tv_fast_blank_level)
      2'h0:    next_fb = 1'b0;
      2'h1:    next_fb = 1'b1;
      2'h2:    next_fb = fb_sync;
      default: next_fb = 1'b0;
    endcase
    next_sb_status    = vcr_slow_blank_status_o;
    next_vcr_sb_level = vcr_slow_blank_level;
    next_vcr_sb_oe    = 1'b0;
    next_tv_sb_level  = tv_slow_blank_level;
    next_tv_sb_oe     = (tv_slow_blank_level != 2'h2);
    case (slow_blank_direction)
      2'h0: begin
        next_vcr_sb_oe = (vcr_slow_blank_level != 2'h2);
      end
      2'h2: begin
        next_sb_status = sb_sync;
      end
      2'h3: begin
        next_sb_status   = sb_sync;
        next_tv_sb_level = sb_sync;
        next_tv_sb_oe    = (sb_sync != 2'h2);
      end
      default: begin
        next_tv_sb_oe = 1'b0;
      end
    endcase
    // Status keeps its capture whenever the VCR pin is not an input
    if (!slow_blank_direction[1]) begin
      next_sb_status = vcr_slow_blank_status_o;
    end
    case (reg_addr_i)
      `VRBC_ADDR_SRC_SEL:    next_rdata = video_source_select;
      `VRBC_ADDR_OUT_EN:     next_rdata = video_output_enables;
      `VRBC_ADDR_GAIN_CLAMP: next_rdata = video_gain_clamp;
      `VRBC_ADDR_BLANK_CTL:  next_rdata = blanking_control;
      default:               next_rdata = 8'h00;
    endcase
  end

  // Output flip-flops
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o             <= 8'h00;
      {tv_composite_src_o, tv_red_src_o, tv_green_src_o, tv_blue_src_o} <= {4{`VRBC_SRC_NONE}};
      {vcr_composite_src_o, vcr_chroma_src_o, modulator_src_o} <= {3{`VRBC_SRC_NONE}};
      {tv_composite_oe_o, tv_red_oe_o, tv_green_oe_o, tv_blue_oe_o} <= 4'h0;
      {vcr_composite_oe_o, vcr_chroma_oe_o, vcr_chroma_gnd_o, modulator_oe_o} <= 4'h0;
      rgb_gain_o              <= 2'h0;
      {vcr_rc_clamp_high_o, vcr_blue_clamp_high_o, enc_rc_clamp_high_o} <= 3'h0;
      {enc_blue_clamp_high_o, enc_green_sync_tip_o} <= 2'h0;
      restore_sync_src_o      <= 2'h0;
      tv_fast_blank_o         <= 1'b0;
      tv_fast_blank_oe_o      <= 1'b0;
      tv_slow_blank_level_o   <= 2'h0;
      tv_slow_blank_oe_o      <= 1'b0;
      vcr_slow_blank_level_o  <= 2'h0;
      vcr_slow_blank_oe_o     <= 1'b0;
      vcr_slow_blank_status_o <= 2'h0;
    end else begin
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
      tv_composite_src_o      <= next_tv_comp_src;
      tv_composite_oe_o       <= en_tv[0] & tv_valid[0];
      tv_red_src_o            <= next_tv_red_src;
      tv_red_oe_o             <= en_tv[1] & tv_valid[1];
      tv_green_src_o          <= next_tv_green_src;
      tv_green_oe_o           <= en_tv[2] & tv_valid[2];
      tv_blue_src_o           <= next_tv_blue_src;
      tv_blue_oe_o            <= en_tv[3] & tv_valid[3];
      vcr_composite_src_o     <= next_vcr_comp_src;
      vcr_composite_oe_o      <= en_vcr[0] & vcr_valid[0];
      vcr_chroma_src_o        <= next_vcr_chroma_src;
      vcr_chroma_oe_o         <= next_vcr_chroma_oe;
      vcr_chroma_gnd_o        <= next_vcr_chroma_gnd;
      modulator_src_o         <= next_rf_src;
      modulator_oe_o          <= next_rf_oe;
      rgb_gain_o              <= video_gain_clamp[`VRBC_GAIN_LSB +: 2];
      vcr_rc_clamp_high_o     <= next_vcr_rc_high;
      vcr_blue_clamp_high_o   <= next_vcr_blue_high;
      enc_rc_clamp_high_o     <= next_enc_rc_high;
      enc_blue_clamp_high_o   <= next_enc_blue_high;
      enc_green_sync_tip_o    <= next_sync_tip;
      restore_sync_src_o      <= next_restore_src;
      tv_fast_blank_o         <= next_fb;
      tv_fast_blank_oe_o      <= next_fb_oe;
      tv_slow_blank_level_o   <= next_tv_sb_level;
      tv_slow_blank_oe_o      <= next_tv_sb_oe;
      vcr_slow_blank_level_o  <= next_vcr_sb_level;
      vcr_slow_blank_oe_o     <= next_vcr_sb_oe;
      vcr_slow_blank_status_o <= next_sb_status;
    end
  end
endmodule // vrbc_ctrl

// ### testbench/vrbc_ctrl_monitor.sv
`timescale 1ns/1ps
module vrbc_ctrl_monitor (
  input wire       mclk_i,
  input wire       reset_n_i,
  input wire       reg_wr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire       auto_setup_i,
  input wire       standby_i,
  input wire [3:0] tv_composite_src_o,
  input wire [3:0] tv_red_src_o,
  input wire [3:0] tv_green_src_o,
  input wire [3:0] tv_blue_src_o,
  input wire       tv_composite_oe_o,
  input wire       tv_red_oe_o,
  input wire       tv_green_oe_o,
  input wire       tv_blue_oe_o,
  input wire       vcr_chroma_oe_o,
  input wire       vcr_chroma_gnd_o,
  input wire [1:0] restore_sync_src_o,
  input wire       tv_slow_blank_oe_o,
  input wire [1:0] tv_slow_blank_level_o,
  input wire       vcr_slow_blank_oe_o,
  input wire [1:0] vcr_slow_blank_status_o
);
  // Checks wait until the internal reset copy has let go
  logic [1:0]  up_cnt;
  wire  [15:0] tv_src = {tv_composite_src_o, tv_red_src_o, tv_green_src_o, tv_blue_src_o};
  wire  [3:0]  tv_oe  = {tv_composite_oe_o, tv_red_oe_o, tv_green_oe_o, tv_blue_oe_o};
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) up_cnt <= 2'h0;
    else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i || up_cnt != 2'h3);
  sequence s_tv_wr_settle;
    ##1 !auto_setup_i && !standby_i && !(reg_wr_i && reg_addr_i == 8'h04);
  endsequence
  sequence s_tv_enc_wr;
    reg_wr_i && reg_addr_i == 8'h04 && reg_wdata_i[2:0] == 3'h1 ##0 s_tv_wr_settle;
  endsequence
  sequence s_tv_rsv_wr;
    reg_wr_i && reg_addr_i == 8'h04 && reg_wdata_i[2:1] == 2'h3 ##0 s_tv_wr_settle;
  endsequence
  a_tv_enc_route: assert property (s_tv_enc_wr |=> tv_src == 16'h1356)
    else $error("tv routing for encoder code wrong");
  a_tv_reserved_float: assert property (s_tv_rsv_wr |=> tv_oe == 4'h0)
    else $error("tv outputs driven on reserved code");
  a_auto_tv_loop: assert property (auto_setup_i |=> tv_src == 16'h789a)
    else $error("tv loop-through routing missing");
  a_auto_enables_on: assert property (auto_setup_i |=> tv_oe == 4'hf)
    else $error("enable bits not overridden in auto");
  a_auto_restore_src: assert property (auto_setup_i |=> restore_sync_src_o == 2'h2)
    else $error("restore source not forced in auto");
  a_chroma_gnd_float: assert property (vcr_chroma_gnd_o |-> !vcr_chroma_oe_o)
    else $error("chroma pin driven while grounded");
  a_status_hold: assert property (vcr_slow_blank_oe_o |-> $stable(vcr_slow_blank_status_o))
    else $error("status moved while pin is output");
  a_slow_level_legal: assert property (tv_slow_blank_oe_o |-> tv_slow_blank_level_o != 2'h2)
    else $error("reserved slow blank level driven");
  a_rdata_unmapped: assert property (reg_rd_i && (reg_addr_i < 8'h04 || reg_addr_i > 8'h07)
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule // vrbc_ctrl_monitor

bind vrbc_ctrl vrbc_ctrl_monitor u_vrbc_ctrl_monitor (.*);

// ### testbench/vrbc_scart_model.sv
`timescale 1ns/1ps
// VCR connector blanking lines, levels move just after the clock edge
module vrbc_scart_model (
  input  wire        mclk_i,
  input  wire        fb_i,
  input  wire  [1:0] sb_i,
  output logic       fb_o = 1'b0,
  output logic [1:0] sb_o = 2'h0
);
  always @(posedge mclk_i) begin
    fb_o <= fb_i;
    sb_o <= sb_i;
  end
endmodule // vrbc_scart_model

// ### testbench/video_route_blanking_ctrl_tb.sv
`timescale 1ns/1ps
module video_route_blanking_ctrl_tb;
  logic       mclk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic       auto_setup_i = 0, standby_i = 0, fb_cmd = 0;
  logic [1:0] sb_cmd = 2'h0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  wire  [7:0] reg_rdata_o;
  wire        vcr_fast_blank_i;
  wire  [1:0] vcr_slow_blank_i, rgb_gain_o, restore_sync_src_o, tv_slow_blank_level_o;
  wire  [1:0] vcr_slow_blank_level_o, vcr_slow_blank_status_o;
  wire  [3:0] tv_composite_src_o, tv_red_src_o, tv_green_src_o, tv_blue_src_o;
  wire  [3:0] vcr_composite_src_o, vcr_chroma_src_o, modulator_src_o;
  wire        tv_composite_oe_o, tv_red_oe_o, tv_green_oe_o, tv_blue_oe_o, modulator_oe_o;
  wire        vcr_composite_oe_o, vcr_chroma_oe_o, vcr_chroma_gnd_o, enc_green_sync_tip_o;
  wire        vcr_rc_clamp_high_o, vcr_blue_clamp_high_o, enc_rc_clamp_high_o;
  wire        enc_blue_clamp_high_o, tv_fast_blank_o, tv_fast_blank_oe_o;
  wire        tv_slow_blank_oe_o, vcr_slow_blank_oe_o;
  wire [15:0] tv_src = {tv_composite_src_o, tv_red_src_o, tv_green_src_o, tv_blue_src_o};
  wire  [3:0] tv_oe  = {tv_composite_oe_o, tv_red_oe_o, tv_green_oe_o, tv_blue_oe_o};
  integer     n_fail = 0, tests_run = 0, cyc = 0, i;
  logic [1:0] hp;

  vrbc_ctrl u_vrbc_ctrl (.*);
  vrbc_scart_model u_vrbc_scart_model (.mclk_i(mclk_i), .fb_i(fb_cmd), .sb_i(sb_cmd),
    .fb_o(vcr_fast_blank_i), .sb_o(vcr_slow_blank_i));

  always #4 mclk_i = ~mclk_i;

  task tally_and_finish;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end

  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Write, then let the decoded outputs settle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_wr_i = 1; reg_addr_i = a; reg_wdata_i = d;
    @(negedge mclk_i);
    reg_wr_i = 0;
    repeat (2) @(negedge mclk_i);
  endtask

  task rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk_i);
    reg_rd_i = 1; reg_addr_i = a;
    @(negedge mclk_i);
    reg_rd_i = 0;
    chk("rdata", {8'h00, reg_rdata_o}, {8'h00, exp});
  endtask

  function logic [15:0] tv_exp(input logic [2:0] c);
    case (c)
      3'h1: tv_exp = 16'h1356;
      3'h2: tv_exp = 16'h1300;
      3'h3: tv_exp = 16'h2400;
      3'h4: tv_exp = 16'h789a;
      3'h5: tv_exp = 16'hb000;
      default: tv_exp = 16'h0000;
    endcase
  endfunction

  function logic [7:0] vcr_exp(input logic [2:0] c);
    case (c)
      3'h1: vcr_exp = 8'h13;
      3'h2: vcr_exp = 8'h24;
      3'h3: vcr_exp = 8'hb0;
      3'h4: vcr_exp = 8'h78;
      default: vcr_exp = 8'h00;
    endcase
  endfunction

  function logic [3:0] oe4(input logic [15:0] s);
    oe4 = {|s[15:12], |s[11:8], |s[7:4], |s[3:0]};
  endfunction

  initial begin
    repeat (10) @(negedge mclk_i);
    reset_n_i = 1;
    repeat (3) @(negedge mclk_i);
    rdc(8'h04, 8'h99);
    rdc(8'h05, 8'h00);
    rdc(8'h06, 8'h04);
    rdc(8'h07, 8'h00);
    wr(8'h03, 8'hff);
    rdc(8'h03, 8'h00);
    chk("tv_oe_rst", tv_oe, 4'h0);
    wr(8'h05, 8'h7f);
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h04, {i[1:0], i[2:0], i[2:0]});
      chk("tv_src", tv_src, tv_exp(i[2:0]));
      chk("tv_oe", tv_oe, oe4(tv_exp(i[2:0])));
      chk("vcr", {vcr_composite_src_o, vcr_chroma_src_o, 2'h0, vcr_composite_oe_o,
        vcr_chroma_oe_o}, {vcr_exp(i[2:0]), oe4({8'h00, vcr_exp(i[2:0])})});
      chk("rf", {modulator_src_o, modulator_oe_o}, {(i[1:0] == 2'h0) ? 4'h1 :
        (i[1:0] == 2'h1) ? 4'h5 : (i[1:0] == 2'h2) ? 4'h7 : 4'h0, i[1:0] != 2'h3});
    end
    wr(8'h05, 8'h20);
    wr(8'h04, 8'h61);
    chk("chroma", {vcr_chroma_gnd_o, vcr_chroma_oe_o}, 2'h1);
    wr(8'h05, 8'ha0);
    chk("chroma", {vcr_chroma_gnd_o, vcr_chroma_oe_o}, 2'h2);
    chk("tv_oe_off", tv_oe, 4'h0);
    auto_setup_i = 1;
    repeat (2) @(negedge mclk_i);
    chk("auto_src", tv_src, 16'h789a);
    chk("auto_oe", tv_oe, 4'hf);
    chk("auto_rsrc", restore_sync_src_o, 2'h2);
    chk("auto_fb", tv_fast_blank_oe_o, 1'b1);
    auto_setup_i = 0;
    standby_i = 1;
    repeat (2) @(negedge mclk_i);
    chk("standby_flag_src", tv_src, 16'h789a);
    chk("standby_flag_oe", tv_oe, 4'h0);
    chk("standby_flag_fb", tv_fast_blank_oe_o, 1'b0);
    standby_i = 0;
    wr(8'h05, 8'h04);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h06, {i[1:0], 1'b0, i[1], i[0], i[0], i[1:0]});
      hp = (i == 1) ? 2'h2 : (i == 2) ? 2'h3 : 2'h0;
      chk("gain", rgb_gain_o, i[1:0]);
      chk("vclamp", {vcr_rc_clamp_high_o, vcr_blue_clamp_high_o}, hp);
      chk("eclamp", {enc_rc_clamp_high_o, enc_blue_clamp_high_o}, hp);
      chk("rsrc", restore_sync_src_o, i[1:0]);
      chk("tip", enc_green_sync_tip_o, i == 3);
    end
    wr(8'h06, 8'h20);
    chk("tip_bit", enc_green_sync_tip_o, 1'b1);
    wr(8'h05, 8'h40);
    fb_cmd = 1;
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h07, {2'h0, i[1:0], i[1:0], i[1:0]});
      chk("fb", {tv_fast_blank_oe_o, tv_fast_blank_o & tv_fast_blank_oe_o},
        {i != 3, i == 1 || i == 2});
      chk("tsb", {tv_slow_blank_oe_o, tv_slow_blank_oe_o ? tv_slow_blank_level_o : 2'h0},
        {i != 2, i == 2 ? 2'h0 : i[1:0]});
      chk("vsb", {vcr_slow_blank_oe_o, vcr_slow_blank_oe_o ? vcr_slow_blank_level_o : 2'h0},
        {i != 2, i == 2 ? 2'h0 : i[1:0]});
    end
    sb_cmd = 2'h1;
    wr(8'h07, 8'h80);
    repeat (3) @(negedge mclk_i);
    chk("dir_in", {vcr_slow_blank_oe_o, tv_slow_blank_oe_o, tv_slow_blank_level_o,
      vcr_slow_blank_status_o}, 6'h11);
    wr(8'h07, 8'hc0);
    chk("dir_mirror", {tv_slow_blank_oe_o, tv_slow_blank_level_o}, 3'h5);
    wr(8'h07, 8'h40);
    chk("dir_rsv", {vcr_slow_blank_oe_o, tv_slow_blank_oe_o}, 2'h0);
    wr(8'h07, 8'h00);
    sb_cmd = 2'h3;
    repeat (5) @(negedge mclk_i);
    chk("hold", {vcr_slow_blank_oe_o, vcr_slow_blank_status_o}, 3'h5);
    tally_and_finish;
  end
endmodule // video_route_blanking_ctrl_tb
